/* rtl/lpicu_pkg.sv */
/*
 * Constants, command codes and state types of the LCD power and indicator
 * command unit.
 * Assumes a single 20 MHz clock and command bytes delivered by same-clock
 * host interface logic.
 */
// Overview of operation
// - Byte 00100xxx loads its low three bits as regulator resistor ratio.
// - Byte 10000001 enters contrast mode; next command byte is contrast value.
// - In contrast mode only the contrast write is accepted, nothing else.
// - Contrast write keeps six low bits, 64 levels; top two bits ignored.
// - After storing the contrast value, normal decoding resumes.
// - Indicator state changes only by its own commands, never by others.
// - Indicator drive appears on frame polarity and static indicator outputs.
// - Byte 10101101 switches indicator on and awaits its register byte.
// - Byte 10101100 switches indicator off as a single-byte command.
// - After indicator-on only the indicator register write is accepted.
// - Indicator-register mode ends once the register byte is stored.
// - Mode bits: 00 off, 01 0.5 s blink, 10 1 s blink, 11 steady.
// - Power save sleeps with indicator off, stands by with it on.
// - Sleep ends with display on or entire off plus indicator on.
// - Sleep stops the oscillator and the LCD supply circuits.
// - Sleep halts LCD driving; segment and common outputs go to ground.
// - Sleep and standby keep settings and leave display memory accessible.
// - Standby stops supply, grounds outputs, keeps indicator drive running.
// - Reset command during standby moves the device to sleep.
// - Entire-display-on while display is off enters power save.
// - Display on/off command: low bit high turns on, low turns off.
package lpicu_pkg;

    // *****************************************************************
    // Command codes
    // *****************************************************************
    localparam logic [7:0] CMD_RATIO_MASK    = 8'hf8;
    localparam logic [7:0] CMD_RATIO_BASE    = 8'h20;
    localparam logic [7:0] CMD_CONTRAST_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF       = 8'hac;
    localparam logic [7:0] CMD_IND_ON        = 8'had;
    localparam logic [7:0] CMD_DISP_OFF      = 8'hae;
    localparam logic [7:0] CMD_DISP_ON       = 8'haf;
    localparam logic [7:0] CMD_ENTIRE_OFF    = 8'ha4;
    localparam logic [7:0] CMD_ENTIRE_ON     = 8'ha5;
    localparam logic [7:0] CMD_RESET         = 8'he2;
    localparam logic [7:0] CMD_NOP           = 8'he3;

    // *****************************************************************
    // Field widths and positions
    // *****************************************************************
    localparam int RATIO_W     = 3;
    localparam int CONTRAST_W  = 6;
    localparam int IND_MODE_W  = 2;

    localparam logic [1:0] IND_MODE_OFF    = 2'h0;
    localparam logic [1:0] IND_MODE_FAST   = 2'h1;
    localparam logic [1:0] IND_MODE_SLOW   = 2'h2;
    localparam logic [1:0] IND_MODE_STEADY = 2'h3;

    // *****************************************************************
    // Reset values
    // *****************************************************************
    localparam logic [2:0] RATIO_RST    = 3'h0;
    localparam logic [5:0] CONTRAST_RST = 6'h20;
    localparam logic [1:0] IND_MODE_RST = 2'h0;

    // *****************************************************************
    // Timing
    // *****************************************************************
    localparam int unsigned CLK_KHZ        = 20000;
    localparam int unsigned BLINK_FAST_MS  = 500;
    localparam int unsigned BLINK_SLOW_MS  = 1000;
    localparam int unsigned FRAME_HALF_US  = 8000;
    localparam int unsigned BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
    localparam int unsigned BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
    localparam int unsigned FRAME_HALF_CYC = FRAME_HALF_US * CLK_KHZ / 1000;

    // *****************************************************************
    // States
    // *****************************************************************
    typedef enum logic [1:0] {
        DEC_NORMAL,
        DEC_CONTRAST,
        DEC_INDICATOR
    } lpicu_dec_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_STANDBY
    } lpicu_pwr_t;

endpackage

/* rtl/lpicu_toggle_div.sv */
/*
 * Divider that toggles its output every HALF_CYC clocks while run_i is high.
 * Assumes run_i comes from logic on the same clock.
 */
`timescale 1ns/10ps
module lpicu_toggle_div #(
    parameter int unsigned HALF_CYC = 16
) (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      phase_o
);

    // *****************************************************************
    // Divider
    // *****************************************************************
    logic [31:0] cnt_reg;

    // Holding the count while stopped models a halted oscillator
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 32'h0;
        end else if (run_i) begin
            if (cnt_reg >= 32'(HALF_CYC - 1)) begin
                cnt_reg <= 32'h0;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_o <= 1'b0;
        end else if (run_i && cnt_reg >= 32'(HALF_CYC - 1)) begin
            phase_o <= ~phase_o;
        end
    end

endmodule

/* rtl/lpicu_cmd_unit.sv */
/*
 * Command interpreter for drive ratio, contrast, static indicator,
 * display on/off, entire display and power save.
 * Assumes host bytes arrive as one-cycle strobes from interface logic
 * running on ref_clk_i, so no synchroniser is placed on them.
 */
`timescale 1ns/10ps
module lpicu_cmd_unit
    import lpicu_pkg::*;
#(
    parameter int unsigned FRAME_CYC = lpicu_pkg::FRAME_HALF_CYC,
    parameter int unsigned FAST_CYC  = lpicu_pkg::BLINK_FAST_CYC,
    parameter int unsigned SLOW_CYC  = lpicu_pkg::BLINK_SLOW_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       wr_stb_i,
    input  wire logic       register_select_line_i,
    input  wire logic [7:0] wr_data_i,
    output logic [2:0]      regulator_resistor_ratio_o,
    output logic [5:0]      contrast_level_bits_o,
    output logic            display_on_o,
    output logic            entire_display_on_o,
    output logic            indicator_on_o,
    output logic [1:0]      indicator_mode_o,
    output logic            frame_polarity_out_o,
    output logic            static_indicator_out_o,
    output logic            sleep_o,
    output logic            standby_o,
    output logic            osc_enable_o,
    output logic            lcd_supply_enable_o,
    output logic            lcd_drive_enable_o,
    output logic            ram_access_enable_o,
    output logic            contrast_mode_o,
    output logic            indicator_reg_mode_o,
    output logic            cmd_done_o,
    output logic            reset_cmd_o
);

    import lpicu_pkg::*;

    // *****************************************************************
    // Command strobe and decode
    // *****************************************************************
    logic       cmd_stb;
    logic       is_ratio;
    logic       is_contrast_mode;
    logic       is_ind_on;
    logic       is_ind_off;
    logic       is_disp_on;
    logic       is_disp_off;
    logic       is_entire_on;
    logic       is_entire_off;
    logic       is_reset;
    logic       is_nop;
    logic       normal_cmd;
    lpicu_dec_t dec_reg;
    lpicu_dec_t dec_next;
    lpicu_pwr_t pwr_reg;
    lpicu_pwr_t pwr_next;

    // Display data writes never reach the decoder
    assign cmd_stb = wr_stb_i && !register_select_line_i;

    // Opcodes are only decoded while no second byte is pending
    assign normal_cmd = cmd_stb && (dec_reg == DEC_NORMAL);

    assign is_ratio         = normal_cmd &&
                              ((wr_data_i & CMD_RATIO_MASK) == CMD_RATIO_BASE);
    assign is_contrast_mode = normal_cmd && (wr_data_i == CMD_CONTRAST_MODE);
    assign is_ind_on        = normal_cmd && (wr_data_i == CMD_IND_ON);
    assign is_ind_off       = normal_cmd && (wr_data_i == CMD_IND_OFF);
    assign is_disp_on       = normal_cmd && (wr_data_i == CMD_DISP_ON);
    assign is_disp_off      = normal_cmd && (wr_data_i == CMD_DISP_OFF);
    assign is_entire_on     = normal_cmd && (wr_data_i == CMD_ENTIRE_ON);
    assign is_entire_off    = normal_cmd && (wr_data_i == CMD_ENTIRE_OFF);
    assign is_reset         = normal_cmd && (wr_data_i == CMD_RESET);
    // Decoded but drives nothing; cmd_done_o follows every command byte anyway
    assign is_nop           = normal_cmd && (wr_data_i == CMD_NOP);

    // *****************************************************************
    // Decoder mode machine
    // *****************************************************************
    always_comb begin
        dec_next = dec_reg;
        case (dec_reg)
            DEC_NORMAL: begin
                if (is_contrast_mode) begin
                    dec_next = DEC_CONTRAST;
                end else if (is_ind_on) begin
                    dec_next = DEC_INDICATOR;
                end
            end
            DEC_CONTRAST: begin
                if (cmd_stb) begin
                    dec_next = DEC_NORMAL;
                end
            end
            DEC_INDICATOR: begin
                if (cmd_stb) begin
                    dec_next = DEC_NORMAL;
                end
            end
            default: begin
                dec_next = DEC_NORMAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dec_reg <= DEC_NORMAL;
        end else begin
            dec_reg <= dec_next;
        end
    end

    // *****************************************************************
    // Drive voltage settings
    // *****************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            regulator_resistor_ratio_o <= RATIO_RST;
        end else if (is_ratio) begin
            regulator_resistor_ratio_o <= wr_data_i[RATIO_W-1:0];
        end
    end

    // Any command byte in contrast mode is the value; bits 7:6 dropped
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            contrast_level_bits_o <= CONTRAST_RST;
        end else if (cmd_stb && dec_reg == DEC_CONTRAST) begin
            contrast_level_bits_o <= wr_data_i[CONTRAST_W-1:0];
        end
    end

    // *****************************************************************
    // Static indicator
    // *****************************************************************
    // Only the indicator's own bytes reach these flops
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            indicator_on_o <= 1'b0;
        end else if (is_ind_on) begin
            indicator_on_o <= 1'b1;
        end else if (is_ind_off) begin
            indicator_on_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            indicator_mode_o <= IND_MODE_RST;
        end else if (cmd_stb && dec_reg == DEC_INDICATOR) begin
            indicator_mode_o <= wr_data_i[IND_MODE_W-1:0];
        end
    end

    // *****************************************************************
    // Display on/off and entire display
    // *****************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            display_on_o <= 1'b0;
        end else if (is_disp_on) begin
            display_on_o <= 1'b1;
        end else if (is_disp_off) begin
            display_on_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            entire_display_on_o <= 1'b0;
        end else if (is_entire_on) begin
            entire_display_on_o <= 1'b1;
        end else if (is_entire_off) begin
            entire_display_on_o <= 1'b0;
        end
    end

    // *****************************************************************
    // Power save machine
    // *****************************************************************
    logic ps_cond;

    // Entire-on with display off is the power save compound
    assign ps_cond = entire_display_on_o && !display_on_o;

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_ACTIVE: begin
                if (ps_cond) begin
                    if (indicator_on_o) begin
                        pwr_next = PWR_STANDBY;
                    end else begin
                        pwr_next = PWR_SLEEP;
                    end
                end
            end
            PWR_SLEEP: begin
                // Both the power save release and indicator-on are needed
                if (!ps_cond && indicator_on_o) begin
                    pwr_next = PWR_ACTIVE;
                end
            end
            PWR_STANDBY: begin
                if (is_reset) begin
                    pwr_next = PWR_SLEEP;
                end else if (!ps_cond) begin
                    pwr_next = PWR_ACTIVE;
                end
            end
            default: begin
                pwr_next = PWR_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_reg <= PWR_ACTIVE;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // *****************************************************************
    // Indicator timing
    // *****************************************************************
    logic osc_run;
    logic frame_phase;
    logic fast_phase;
    logic slow_phase;

    // Oscillator halts in sleep, so all timing freezes with it
    assign osc_run = (pwr_reg != PWR_SLEEP);

    lpicu_toggle_div #(
        .HALF_CYC (FRAME_CYC)
    ) u_frame_div (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (osc_run),
        .phase_o   (frame_phase)
    );

    lpicu_toggle_div #(
        .HALF_CYC (FAST_CYC)
    ) u_fast_div (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (osc_run),
        .phase_o   (fast_phase)
    );

    lpicu_toggle_div #(
        .HALF_CYC (SLOW_CYC)
    ) u_slow_div (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (osc_run),
        .phase_o   (slow_phase)
    );

    logic ind_lit;

    always_comb begin
        ind_lit = 1'b0;
        if (indicator_on_o) begin
            case (indicator_mode_o)
                IND_MODE_OFF:    ind_lit = 1'b0;
                IND_MODE_FAST:   ind_lit = fast_phase;
                IND_MODE_SLOW:   ind_lit = slow_phase;
                IND_MODE_STEADY: ind_lit = 1'b1;
                default:         ind_lit = 1'b0;
            endcase
        end
    end

    // *****************************************************************
    // Indicator electrodes
    // *****************************************************************
    // Lit means the two electrodes sit in antiphase; equal phase keeps
    // the indicator dark with no DC across the liquid crystal
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_polarity_out_o <= 1'b0;
        end else if (pwr_reg == PWR_SLEEP) begin
            frame_polarity_out_o <= 1'b0;
        end else begin
            frame_polarity_out_o <= frame_phase;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            static_indicator_out_o <= 1'b0;
        end else if (pwr_reg == PWR_SLEEP) begin
            static_indicator_out_o <= 1'b0;
        end else begin
            static_indicator_out_o <= frame_phase ^ ind_lit;
        end
    end

    // *****************************************************************
    // Power and drive enables
    // *****************************************************************
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_enable_o <= 1'b1;
        end else begin
            osc_enable_o <= (pwr_next != PWR_SLEEP);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lcd_supply_enable_o <= 1'b1;
        end else begin
            lcd_supply_enable_o <= (pwr_next == PWR_ACTIVE);
        end
    end

    // Low forces every segment and common driver to ground
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lcd_drive_enable_o <= 1'b1;
        end else begin
            lcd_drive_enable_o <= (pwr_next == PWR_ACTIVE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sleep_o   <= 1'b0;
            standby_o <= 1'b0;
        end else begin
            sleep_o   <= (pwr_next == PWR_SLEEP);
            standby_o <= (pwr_next == PWR_STANDBY);
        end
    end

    // Settings are never cleared by power save and the host path is
    // not gated, so memory stays reachable in both low power states
    assign ram_access_enable_o = 1'b1;

    // *****************************************************************
    // Status and pulses
    // *****************************************************************
    assign contrast_mode_o      = (dec_reg == DEC_CONTRAST);
    assign indicator_reg_mode_o = (dec_reg == DEC_INDICATOR);

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_done_o <= 1'b0;
        end else begin
            cmd_done_o <= cmd_stb;
        end
    end

    // Reset command is handed on to address logic outside this block
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reset_cmd_o <= 1'b0;
        end else begin
            reset_cmd_o <= is_reset;
        end
    end

endmodule

/* verification/lpicu_host_model.sv */
/*
 * Host model: writes command and data bytes to the command unit.
 * Assumes the bench shares ref_clk_i and calls the tasks in turn.
 */
`timescale 1ns/10ps
module lpicu_host_model (
    input  wire logic       ref_clk_i,
    output logic            wr_stb_o,
    output logic            rs_o,
    output logic [7:0]      data_o
);
    // ****************************************************************
    // Byte writer, lines change at the falling edge
    // ****************************************************************
    initial begin
        wr_stb_o = 1'b0;
        rs_o     = 1'b1;
        data_o   = 8'h00;
    end
    task automatic send(input logic [7:0] b, input logic rs);
        @(negedge ref_clk_i);
        wr_stb_o = 1'b1;
        rs_o     = rs;
        data_o   = b;
        @(negedge ref_clk_i);
        wr_stb_o = 1'b0;
        rs_o     = ~rs;
        data_o   = ~b; // Idle bus must not echo the last byte
    endtask
    task automatic contrast(input logic [7:0] v);
        send(8'h81, 1'b0);
        send(v, 1'b0);
    endtask
    task automatic indicator(input logic [7:0] m);
        send(8'had, 1'b0);
        send(m, 1'b0);
    endtask
    task automatic wake(input logic [7:0] m);
        send(8'haf, 1'b0);
        indicator(m);
    endtask
endmodule

/* verification/lpicu_checker.sv */
/*
 * Port checker for the command unit.
 * Assumes one clock and the asynchronous active-low reset.
 */
`timescale 1ns/10ps
module lpicu_checker (
    input wire logic       ref_clk_i,
    input wire logic       rstn_i,
    input wire logic       wr_stb_i,
    input wire logic       register_select_line_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [2:0] regulator_resistor_ratio_o,
    input wire logic [5:0] contrast_level_bits_o,
    input wire logic       indicator_on_o,
    input wire logic [1:0] indicator_mode_o,
    input wire logic       sleep_o,
    input wire logic       standby_o,
    input wire logic       osc_enable_o,
    input wire logic       lcd_supply_enable_o,
    input wire logic       lcd_drive_enable_o,
    input wire logic       contrast_mode_o,
    input wire logic       indicator_reg_mode_o,
    input wire logic       cmd_done_o
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    logic take;
    logic cmd;
    assign take = wr_stb_i && !register_select_line_i;
    assign cmd  = take && !contrast_mode_o && !indicator_reg_mode_o;
    sequence s_entry;
        cmd && wr_data_i == 8'h81;
    endsequence
    sequence s_value;
        contrast_mode_o && take;
    endsequence
    a_contrast_enter: assert property (s_entry |=> contrast_mode_o)
        else $error("contrast mode not entered");
    a_ratio_load: assert property (cmd && wr_data_i[7:3] == 5'h04 |=>
        regulator_resistor_ratio_o == $past(wr_data_i[2:0]))
        else $error("ratio not loaded");
    a_contrast_pair: assert property (s_value |=>
        contrast_level_bits_o == $past(wr_data_i[5:0]) && !contrast_mode_o)
        else $error("contrast pair wrong");
    a_contrast_wait: assert property (contrast_mode_o && !take |=>
        contrast_mode_o) else $error("contrast mode lost");
    a_ind_on: assert property (cmd && wr_data_i == 8'had |=>
        indicator_on_o && indicator_reg_mode_o) else $error("ind on");
    a_ind_off: assert property (cmd && wr_data_i == 8'hac |=>
        !indicator_on_o && !indicator_reg_mode_o) else $error("ind off");
    a_ind_store: assert property (take && indicator_reg_mode_o |=>
        indicator_mode_o == $past(wr_data_i[1:0]) && !indicator_reg_mode_o)
        else $error("indicator mode not stored");
    a_nop_keep: assert property (cmd && wr_data_i == 8'he3 |=>
        $stable(regulator_resistor_ratio_o) && $stable(indicator_mode_o)
        && $stable(contrast_level_bits_o)) else $error("nop changed state");
    a_data_ignored: assert property (wr_stb_i && register_select_line_i
        |=> !cmd_done_o && $stable(indicator_mode_o))
        else $error("data byte taken as command");
    a_sleep_stop: assert property (sleep_o |-> !osc_enable_o &&
        !lcd_supply_enable_o && !lcd_drive_enable_o) else $error("sleep");
    a_standby_run: assert property (standby_o |-> osc_enable_o &&
        !lcd_supply_enable_o && !lcd_drive_enable_o) else $error("standby");
    a_standby_reset: assert property (standby_o && cmd &&
        wr_data_i == 8'he2 |-> ##[1:3] sleep_o) else $error("no sleep");
endmodule

bind lpicu_cmd_unit lpicu_checker u_chk (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i),
    .register_select_line_i(register_select_line_i),
    .regulator_resistor_ratio_o(regulator_resistor_ratio_o),
    .contrast_level_bits_o(contrast_level_bits_o),
    .indicator_on_o(indicator_on_o), .indicator_mode_o(indicator_mode_o),
    .sleep_o(sleep_o), .standby_o(standby_o), .osc_enable_o(osc_enable_o),
    .lcd_supply_enable_o(lcd_supply_enable_o),
    .lcd_drive_enable_o(lcd_drive_enable_o),
    .contrast_mode_o(contrast_mode_o),
    .indicator_reg_mode_o(indicator_reg_mode_o), .cmd_done_o(cmd_done_o));

/* verification/lpicu_cmd_unit_tb.sv */
/*
 * Self-checking bench for the command unit with short blink counts.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
module lpicu_cmd_unit_tb;
    // ****************************************************************
    // Harness
    // ****************************************************************
    logic       clk = 1'b0;
    logic       rstn_i = 1'b0;
    logic       stb, rs, dsp, ent, ion, frm, sti, slp, sby, osc, sup;
    logic       drv, ram, cmd_m, ind_m, done, rst_c;
    logic [7:0] dat;
    logic [2:0] ratio;
    logic [5:0] con;
    logic [1:0] imode;
    int         n_fail = 0;
    int         samples_checked = 0;
    always #25 clk = ~clk;
    lpicu_host_model host (.ref_clk_i(clk), .wr_stb_o(stb), .rs_o(rs),
        .data_o(dat));
    lpicu_cmd_unit #(.FRAME_CYC(4), .FAST_CYC(16), .SLOW_CYC(32)) dut (
        .ref_clk_i(clk), .rstn_i(rstn_i), .wr_stb_i(stb),
        .register_select_line_i(rs), .wr_data_i(dat),
        .regulator_resistor_ratio_o(ratio), .contrast_level_bits_o(con),
        .display_on_o(dsp), .entire_display_on_o(ent), .indicator_on_o(ion),
        .indicator_mode_o(imode), .frame_polarity_out_o(frm),
        .static_indicator_out_o(sti), .sleep_o(slp), .standby_o(sby),
        .osc_enable_o(osc), .lcd_supply_enable_o(sup),
        .lcd_drive_enable_o(drv), .ram_access_enable_o(ram),
        .contrast_mode_o(cmd_m), .indicator_reg_mode_o(ind_m),
        .cmd_done_o(done), .reset_cmd_o(rst_c));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_ratio();
        check(8'(con), 8'h20);
        for (int k = 0; k < 8; k++) begin
            host.send(8'h20 | 8'(k), 1'b0);
            check(8'({ratio, done}), 8'(2 * k + 1));
        end
        host.send(8'h23, 1'b1);
        check(8'({ratio, done}), 8'h0e);
        $display("ratio test done");
    endtask
    task automatic t_contrast();
        host.contrast(8'hff);
        check(8'(con), 8'h3f);
        check(8'(cmd_m), 8'h00);
        host.send(8'h81, 1'b0);
        host.send(8'h05, 1'b1);
        check(8'(cmd_m), 8'h01);
        host.send(8'h24, 1'b0);
        check(8'(con), 8'h24);
        check(8'(ratio), 8'h07);
        host.contrast(8'h20);   // Midpoint when unused
        check(8'(con), 8'h20);
        $display("contrast test done");
    endtask
    task automatic t_indicator();
        for (int m = 0; m < 4; m++) begin
            host.send(8'had, 1'b0);
            check(8'(ion), 8'h01);
            host.send(8'he0 | 8'(m), 1'b0);
            check(8'(imode), 8'(m));
            check(8'(ind_m), 8'h00);
        end
        host.send(8'he3, 1'b0);
        check({imode, con}, 8'he0);
        host.send(8'haf, 1'b0);
        check(8'(dsp), 8'h01);
        host.send(8'hae, 1'b0);
        check(8'({dsp, ion, imode}), 8'h07);
        host.send(8'hac, 1'b0);
        check(8'({ion, ind_m, imode}), 8'h03);
        $display("indicator test done");
    endtask
    task automatic t_power();
        host.send(8'ha5, 1'b0);
        cyc(3);
        check(8'({ent, slp, osc, drv, frm, sti}), 8'h30);
        check(8'({ram, ratio}), 8'h0f);
        host.wake(8'h03);
        cyc(2);
        check(8'(slp), 8'h00);
        host.send(8'hae, 1'b0);
        cyc(2);
        check(8'({sby, sup}), 8'h02);
        repeat (6) begin
            cyc(1);
            check(8'(sti), 8'(!frm));
        end
        host.send(8'he2, 1'b0);
        check(8'(rst_c), 8'h01);
        cyc(3);
        check(8'(slp), 8'h01);
        $display("power test done");
    endtask
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        cyc(8);
        rstn_i = 1'b1;
        t_ratio();
        t_contrast();
        t_indicator();
        t_power();
        print_verdict();
    end
endmodule
